// [ltio_defines.svh]
`ifndef LTIO_DEFINES_SVH
`define LTIO_DEFINES_SVH
// ==========================================
// Register offsets
`define LTIO_CTRL_OFS 8'h00
`define LTIO_LINE_PER_OFS 8'h04
`define LTIO_FRAME_PER_OFS 8'h08
`define LTIO_HEIGHT_OFS 8'h0C
`define LTIO_FILT_OFS 8'h10
`define LTIO_OUT_SEL_OFS 8'h14
`define LTIO_LAG3_OFS 8'h18
`define LTIO_WID3_OFS 8'h1C
`define LTIO_LAG4_OFS 8'h20
`define LTIO_WID4_OFS 8'h24
`define LTIO_HOST_OUT_OFS 8'h28
`define LTIO_STROBE_OFS 8'h2C
`define LTIO_STATUS_OFS 8'h30
// ==========================================
// Control field positions
`define LTIO_SYNC_BIT 0
`define LTIO_ACQ_BIT 1
`define LTIO_CONT_BIT 2
`define LTIO_ANYEDGE_BIT 3
`define LTIO_SRC_LSB 4
`define LTIO_LSEL_BIT 6
`define LTIO_SWTRIG_BIT 8
`define LTIO_FBEGIN_BIT 9
// ==========================================
// Reset values
`define LTIO_CTRL_RST 7'h00
`define LTIO_LINE_PER_RST 24'h0003E8
`define LTIO_FRAME_PER_RST 24'h0186A0
`define LTIO_HEIGHT_RST 16'h0064
`define LTIO_FILT_RST 8'h00
`define LTIO_TIME_RST 24'h000001
// ==========================================
// Timing
`define LTIO_CLK_NS 5
`define LTIO_US_NS 1000
`define LTIO_US_CYC (`LTIO_US_NS / `LTIO_CLK_NS)
`endif

// [ltio_far_side.sv]
`timescale 1ns/100ps
module ltio_far_side (
  // Clock
  input wire logic sys_clk,
  // Lines toward the device
  output logic [1:0] line_in,
  output logic first_timer_done,
  output logic first_counter_done
);
  // ==========================================
  // Idle levels from time zero
  initial begin
    line_in = 2'h0;
    first_timer_done = 1'b0;
    first_counter_done = 1'b0;
  end
  // Spaced end pulses; caller asks one extra to flush a lone frame
  // Gap keeps any output lag inside the source period
  task automatic ticks(input int n, input int gap,
                       input bit ctr);
    repeat (n) begin
      @(posedge sys_clk);
      first_timer_done <= !ctr;
      first_counter_done <= ctr;
      @(posedge sys_clk);
      first_timer_done <= 1'b0;
      first_counter_done <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
  endtask : ticks
  // Hold a level long enough to be judged
  task automatic level(input int b, input logic v, input int hold);
    @(posedge sys_clk);
    line_in[b] <= v;
    repeat (hold) @(posedge sys_clk);
  endtask : level
endmodule : ltio_far_side

// [ltio_glitch_filter.sv]
`timescale 1ns/100ps
module ltio_glitch_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Timebase and setting
  input wire logic us_tick,
  input wire logic [7:0] filt_time,
  // Line
  input wire logic raw_in,
  output logic clean_out
);
  logic [7:0] stable_reg;
  logic clean_reg;
  wire differs = raw_in != clean_reg;
  wire bypass = filt_time == 8'h00;
  wire done = us_tick && (stable_reg == filt_time - 8'h01);
  assign clean_out = clean_reg;

  // Any bounce back to the old level restarts the wait
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stable_reg <= 8'h00;
      clean_reg <= 1'b0;
    end else if (!differs) begin
      stable_reg <= 8'h00;
    end else if (bypass || done) begin
      clean_reg <= raw_in;
      stable_reg <= 8'h00;
    end else if (us_tick) begin
      stable_reg <= stable_reg + 8'h01;
    end
  end

  property p_filt_bypass;
    @(posedge sys_clk) disable iff (!reset_n)
      (bypass && differs) |=> clean_out == $past(raw_in);
  endproperty
  a_filt_bypass: assert property (p_filt_bypass)
    else $error("unfiltered input did not pass");

  property p_filt_on_tick;
    @(posedge sys_clk) disable iff (!reset_n)
      ($changed(clean_out) && $past(filt_time) != 8'h00)
        |-> $past(us_tick);
  endproperty
  a_filt_on_tick: assert property (p_filt_on_tick)
    else $error("filtered input changed off a tick");
endmodule : ltio_glitch_filter

// [ltio_out_pulse.sv]
`timescale 1ns/100ps
module ltio_out_pulse (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Timebase, event and timing
  input wire logic us_tick,
  input wire logic fire,
  input wire logic [23:0] lag,
  input wire logic [23:0] width,
  // Pulse
  output logic pulse_out
);
  ltio_pkg::ltio_pulse_state_type state_reg, state_next;
  logic [23:0] cnt_reg, cnt_next;
  logic out_reg;
  wire [23:0] cnt_inc = cnt_reg + 24'h000001;
  assign pulse_out = out_reg;

  // Events arriving mid-delay or mid-pulse are dropped
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ltio_pkg::pulse_idle: begin
        if (fire) begin
          cnt_next = 24'h000000;
          state_next = (lag == 24'h000000) ? ltio_pkg::pulse_high
                                           : ltio_pkg::pulse_wait;
        end
      end
      ltio_pkg::pulse_wait: begin
        if (us_tick) begin
          cnt_next = (cnt_inc == lag) ? 24'h000000 : cnt_inc;
          if (cnt_inc == lag) state_next = ltio_pkg::pulse_high;
        end
      end
      ltio_pkg::pulse_high: begin
        if (us_tick) begin
          cnt_next = cnt_inc;
          if (cnt_inc >= width) state_next = ltio_pkg::pulse_idle;
        end
      end
      default: state_next = ltio_pkg::pulse_idle;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ltio_pkg::pulse_idle;
      cnt_reg <= 24'h000000;
      out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      out_reg <= state_next == ltio_pkg::pulse_high;
    end
  end

  property p_lag_zero;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_reg == ltio_pkg::pulse_idle && fire && lag == 24'h000000)
        |=> pulse_out;
  endproperty
  a_lag_zero: assert property (p_lag_zero)
    else $error("zero-lag pulse did not start at once");

  property p_busy_ignore;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_reg == ltio_pkg::pulse_wait && fire && !us_tick)
        |=> state_reg == ltio_pkg::pulse_wait
            && cnt_reg == $past(cnt_reg);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("event disturbed a running delay");
endmodule : ltio_out_pulse

// [ltio_pkg.sv]
package ltio_pkg;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    trig_src_line, trig_src_timer, trig_src_counter, trig_src_none
  } ltio_trig_src_type;
  typedef enum logic [1:0] {
    out_sw_level, out_on_exposure, out_on_strobe, out_on_frame
  } ltio_out_sel_type;
  typedef enum {seq_idle, seq_lines, seq_flush} ltio_seq_state_type;
  typedef enum {pulse_idle, pulse_wait, pulse_high} ltio_pulse_state_type;
endpackage : ltio_pkg

// [ltio_trigger_io.sv]
// Functional notes
// - Line exposures start from internal timer, external input or host.
// - Sync off: free-run with separate line and frame period timers.
// - Sync on: exposures paced by the trigger source chosen by selection.
// - Lines per virtual frame equal the programmed frame height.
// - Each trigger starts current exposure and reads out previous line; the trigger after a single frame's last line only reads out.
// - Continuous mode reuses the read-out trigger as next frame's first.
// - Single frame begin starts one frame only while acquisition active.
// - Trigger sources: chosen input line, first timer end, first counter end.
// - Line triggers detect rising edges or any edge per polarity setting.
// - Each input line is debounced, period programmable 0 to 255 us.
// - Each output line picks its own driving event mode.
// - Output delay programmable 0 to 16 s in 1 us steps.
// - Output pulse width programmable 1 to 16 s in 1 us steps.
// - While a delay runs, new events on that output are ignored.
// - Strobe write is bitwise; bit 0 fires line 3, bit 1 line 4.
// - Active level closes output, inactive opens; hold off applies at once.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "ltio_defines.svh"
module ltio_trigger_io (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Trigger sources
  input wire logic [1:0] line_in,
  input wire logic first_timer_done,
  input wire logic first_counter_done,
  // Output lines 3 and 4, high closes the circuit
  output logic [1:0] line_out,
  // Sequencer events
  output logic exposure_start,
  output logic readout_start,
  output logic frame_begin,
  output logic frame_active
);
  // ==========================================
  // Microsecond timebase
  localparam logic [7:0] US_LAST = 8'(`LTIO_US_CYC - 1);
  logic [7:0] div_reg;
  logic us_tick;

  // Tick is a one-cycle enable, all us counters share it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 8'h00;
      us_tick <= 1'b0;
    end else begin
      div_reg <= (div_reg == US_LAST) ? 8'h00 : div_reg + 8'h01;
      us_tick <= div_reg == US_LAST;
    end
  end

  // ==========================================
  // Register decode
  wire wr_ctrl = reg_wr && reg_addr == `LTIO_CTRL_OFS;
  wire wr_lper = reg_wr && reg_addr == `LTIO_LINE_PER_OFS;
  wire wr_fper = reg_wr && reg_addr == `LTIO_FRAME_PER_OFS;
  wire wr_height = reg_wr && reg_addr == `LTIO_HEIGHT_OFS;
  wire wr_filt = reg_wr && reg_addr == `LTIO_FILT_OFS;
  wire wr_osel = reg_wr && reg_addr == `LTIO_OUT_SEL_OFS;
  wire wr_lag3 = reg_wr && reg_addr == `LTIO_LAG3_OFS;
  wire wr_wid3 = reg_wr && reg_addr == `LTIO_WID3_OFS;
  wire wr_lag4 = reg_wr && reg_addr == `LTIO_LAG4_OFS;
  wire wr_wid4 = reg_wr && reg_addr == `LTIO_WID4_OFS;
  wire wr_host = reg_wr && reg_addr == `LTIO_HOST_OUT_OFS;
  wire wr_strobe = reg_wr && reg_addr == `LTIO_STROBE_OFS;
  // Command bits act on the write and are never stored
  wire sw_trig = wr_ctrl && reg_wdata[`LTIO_SWTRIG_BIT];
  wire fbegin_cmd = wr_ctrl && reg_wdata[`LTIO_FBEGIN_BIT];
  wire [1:0] host_output_strobe = wr_strobe ? reg_wdata[1:0] : 2'h0;

  // ==========================================
  // Configuration registers
  logic [6:0] ctrl_reg;
  logic [23:0] line_per_reg, frame_per_reg;
  logic [15:0] height_reg;
  logic [7:0] input_glitch_filter_time;
  logic [3:0] output_event_select;
  logic [23:0] out_pulse_lag [0:1];
  logic [23:0] out_pulse_width [0:1];
  logic [1:0] host_output_level, host_output_hold_select;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `LTIO_CTRL_RST;
      line_per_reg <= `LTIO_LINE_PER_RST;
      frame_per_reg <= `LTIO_FRAME_PER_RST;
      height_reg <= `LTIO_HEIGHT_RST;
      input_glitch_filter_time <= `LTIO_FILT_RST;
      output_event_select <= 4'h0;
      out_pulse_lag[0] <= `LTIO_TIME_RST;
      out_pulse_width[0] <= `LTIO_TIME_RST;
      out_pulse_lag[1] <= `LTIO_TIME_RST;
      out_pulse_width[1] <= `LTIO_TIME_RST;
      host_output_level <= 2'h0;
      host_output_hold_select <= 2'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata[6:0];
      if (wr_lper) line_per_reg <= reg_wdata[23:0];
      if (wr_fper) frame_per_reg <= reg_wdata[23:0];
      if (wr_height) height_reg <= reg_wdata[15:0];
      if (wr_filt) input_glitch_filter_time <= reg_wdata[7:0];
      if (wr_osel) output_event_select <= reg_wdata[3:0];
      if (wr_lag3) out_pulse_lag[0] <= reg_wdata[23:0];
      if (wr_wid3) out_pulse_width[0] <= reg_wdata[23:0];
      if (wr_lag4) out_pulse_lag[1] <= reg_wdata[23:0];
      if (wr_wid4) out_pulse_width[1] <= reg_wdata[23:0];
      if (wr_host) begin
        host_output_level <= reg_wdata[1:0];
        host_output_hold_select <= reg_wdata[3:2];
      end
    end
  end

  wire sync_on = ctrl_reg[`LTIO_SYNC_BIT];
  wire acq_on = ctrl_reg[`LTIO_ACQ_BIT];
  wire cont_on = ctrl_reg[`LTIO_CONT_BIT];
  wire any_edge = ctrl_reg[`LTIO_ANYEDGE_BIT];
  wire line_sel = ctrl_reg[`LTIO_LSEL_BIT];
  ltio_pkg::ltio_trig_src_type trig_src;
  assign trig_src =
    ltio_pkg::ltio_trig_src_type'(ctrl_reg[`LTIO_SRC_LSB +: 2]);

  // ==========================================
  // Input filtering and edge detection
  logic [1:0] clean_line;
  logic sel_dly_reg;

  for (genvar i = 0; i < 2; i++) begin : g_filt
    ltio_glitch_filter u_filt (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .us_tick(us_tick),
      .filt_time(input_glitch_filter_time),
      .raw_in(line_in[i]),
      .clean_out(clean_line[i])
    );
  end

  wire sel_line = clean_line[line_sel];
  // Switching lines may fake one edge; harmless next to a reconfig
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) sel_dly_reg <= 1'b0;
    else sel_dly_reg <= sel_line;
  end
  wire line_rise = sel_line && !sel_dly_reg;
  wire line_edge = any_edge ? (sel_line ^ sel_dly_reg)
                            : line_rise;

  // Trigger initiator selection
  wire sel_trig =
    (trig_src == ltio_pkg::trig_src_line) ? line_edge :
    (trig_src == ltio_pkg::trig_src_timer) ? first_timer_done :
    (trig_src == ltio_pkg::trig_src_counter) ? first_counter_done :
    1'b0;

  // ==========================================
  // Free-running line and frame timers
  logic [23:0] lrun_reg, frun_reg;
  wire lrun_end = us_tick && line_per_reg != 24'h000000
                  && lrun_reg == line_per_reg - 24'h000001;
  wire frun_end = us_tick && frame_per_reg != 24'h000000
                  && frun_reg == frame_per_reg - 24'h000001;

  // Two independent periods; a zero period keeps its timer counting but never ends it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrun_reg <= 24'h000000;
      frun_reg <= 24'h000000;
    end else if (us_tick) begin
      lrun_reg <= lrun_end ? 24'h000000 : lrun_reg + 24'h000001;
      frun_reg <= frun_end ? 24'h000000 : frun_reg + 24'h000001;
    end
  end

  // Line trigger: paced source, plus host trigger at any time
  wire trig_any = (sync_on ? sel_trig : lrun_end)
                  || sw_trig;
  // Frame start: continuous, host command, or free-run frame timer
  wire frame_req = acq_on && (cont_on || fbegin_cmd
                   || (!sync_on && frun_end));

  // ==========================================
  // Virtual frame sequencer
  ltio_pkg::ltio_seq_state_type seq_reg;
  logic [15:0] lcnt_reg;
  logic pend_reg;
  wire [15:0] lcnt_inc = lcnt_reg + 16'h0001;
  wire last_line = lcnt_inc >= height_reg;
  wire chain = cont_on && acq_on;

  // An exposure stays in the sensor until the next trigger
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= ltio_pkg::seq_idle;
      lcnt_reg <= 16'h0000;
      pend_reg <= 1'b0;
      exposure_start <= 1'b0;
      readout_start <= 1'b0;
      frame_begin <= 1'b0;
    end else begin
      exposure_start <= 1'b0;
      readout_start <= 1'b0;
      frame_begin <= 1'b0;
      case (seq_reg)
        ltio_pkg::seq_idle: begin
          if (frame_req) begin
            seq_reg <= ltio_pkg::seq_lines;
            lcnt_reg <= 16'h0000;
            frame_begin <= 1'b1;
          end
        end
        ltio_pkg::seq_lines: begin
          if (trig_any) begin
            exposure_start <= 1'b1;
            readout_start <= pend_reg;
            pend_reg <= 1'b1;
            lcnt_reg <= lcnt_inc;
            if (last_line && chain) begin
              lcnt_reg <= 16'h0000;
              frame_begin <= 1'b1;
            end else if (last_line) begin
              seq_reg <= ltio_pkg::seq_flush;
            end
          end
        end
        ltio_pkg::seq_flush: begin
          if (trig_any) begin
            readout_start <= 1'b1;
            pend_reg <= 1'b0;
            seq_reg <= ltio_pkg::seq_idle;
          end
        end
        default: seq_reg <= ltio_pkg::seq_idle;
      endcase
    end
  end

  // ==========================================
  // Host output level with optional hold
  logic [1:0] applied_lvl_reg;

  // Hold off: level shows at once; hold on: waits for strobe bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) applied_lvl_reg <= 2'h0;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (!host_output_hold_select[i])
          applied_lvl_reg[i] <= host_output_level[i];
        else if (host_output_strobe[i])
          applied_lvl_reg[i] <= host_output_level[i];
      end
    end
  end

  // ==========================================
  // Output channels, one per line
  logic [1:0] chan_pulse;
  logic [1:0] line_out_reg;

  for (genvar i = 0; i < 2; i++) begin : g_out
    ltio_pkg::ltio_out_sel_type osel;
    assign osel =
      ltio_pkg::ltio_out_sel_type'(output_event_select[2*i +: 2]);
    wire fire = (osel == ltio_pkg::out_on_exposure) ? exposure_start :
                (osel == ltio_pkg::out_on_strobe) ? host_output_strobe[i] :
                (osel == ltio_pkg::out_on_frame) ? frame_begin :
                1'b0;
    ltio_out_pulse u_pulse (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .us_tick(us_tick),
      .fire(fire),
      .lag(out_pulse_lag[i]),
      .width(out_pulse_width[i]),
      .pulse_out(chan_pulse[i])
    );
    // Level mode bypasses the pulse channel entirely
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) line_out_reg[i] <= 1'b0;
      else line_out_reg[i] <= (osel == ltio_pkg::out_sw_level)
                              ? applied_lvl_reg[i] : chan_pulse[i];
    end
  end
  assign line_out = line_out_reg;

  // ==========================================
  // Read port and status
  logic [31:0] rdata_reg;
  logic active_reg;
  wire [31:0] status_word = {11'h000, active_reg, line_out_reg,
                             clean_line, lcnt_reg};
  wire [31:0] rd_mux =
    (reg_addr == `LTIO_CTRL_OFS) ? {25'h0000000, ctrl_reg} :
    (reg_addr == `LTIO_LINE_PER_OFS) ? {8'h00, line_per_reg} :
    (reg_addr == `LTIO_FRAME_PER_OFS) ? {8'h00, frame_per_reg} :
    (reg_addr == `LTIO_HEIGHT_OFS) ? {16'h0000, height_reg} :
    (reg_addr == `LTIO_FILT_OFS) ? {24'h000000, input_glitch_filter_time} :
    (reg_addr == `LTIO_OUT_SEL_OFS) ? {28'h0000000, output_event_select} :
    (reg_addr == `LTIO_LAG3_OFS) ? {8'h00, out_pulse_lag[0]} :
    (reg_addr == `LTIO_WID3_OFS) ? {8'h00, out_pulse_width[0]} :
    (reg_addr == `LTIO_LAG4_OFS) ? {8'h00, out_pulse_lag[1]} :
    (reg_addr == `LTIO_WID4_OFS) ? {8'h00, out_pulse_width[1]} :
    (reg_addr == `LTIO_HOST_OUT_OFS) ?
      {28'h0000000, host_output_hold_select, host_output_level} :
    (reg_addr == `LTIO_STATUS_OFS) ? status_word :
    32'h00000000; // Unmapped and write-only read zero

  // Data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h00000000;
      active_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h00000000;
      active_reg <= seq_reg != ltio_pkg::seq_idle;
    end
  end
  assign reg_rdata = rdata_reg;
  assign frame_active = active_reg;

  // ==========================================
  // Checks
  property p_flush_read;
    @(posedge sys_clk) disable iff (!reset_n)
      (seq_reg == ltio_pkg::seq_flush && trig_any)
        |=> readout_start && !exposure_start
            && seq_reg == ltio_pkg::seq_idle;
  endproperty
  a_flush_read: assert property (p_flush_read)
    else $error("flush trigger did not read out last line");

  property p_height;
    @(posedge sys_clk) disable iff (!reset_n)
      (seq_reg == ltio_pkg::seq_lines && trig_any && last_line && !chain)
        |=> seq_reg == ltio_pkg::seq_flush && lcnt_reg == $past(lcnt_inc);
  endproperty
  a_height: assert property (p_height)
    else $error("frame did not end at programmed height");

  property p_chain;
    @(posedge sys_clk) disable iff (!reset_n)
      (seq_reg == ltio_pkg::seq_lines && trig_any && last_line && chain)
        |=> seq_reg == ltio_pkg::seq_lines && lcnt_reg == 16'h0000
            && frame_begin;
  endproperty
  a_chain: assert property (p_chain)
    else $error("continuous frame did not chain");

  property p_begin_acq;
    @(posedge sys_clk) disable iff (!reset_n)
      frame_begin |-> $past(acq_on);
  endproperty
  a_begin_acq: assert property (p_begin_acq)
    else $error("frame began with acquisition stopped");

  property p_level;
    @(posedge sys_clk) disable iff (!reset_n)
      (output_event_select[1:0] == 2'h0 && !host_output_hold_select[0])
        [*3] |-> line_out[0] == $past(host_output_level[0], 2);
  endproperty
  a_level: assert property (p_level)
    else $error("host level not applied on line 3");

  property p_tick_gap;
    @(posedge sys_clk) disable iff (!reset_n)
      us_tick |=> !us_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("us tick repeated too soon");
endmodule : ltio_trigger_io

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  // ==========================================
  // Signals
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] line_in, line_out, prv = 2'h0;
  logic tmr, cnt, exp_p, ro_p, fb_p, f_act;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_exp, n_ro, n_fb, h, n_rise[2];
  realtime t_take, t0, t_rise[2], t_fall[2];
  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;
  ltio_trigger_io i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
    .first_timer_done(tmr), .first_counter_done(cnt),
    .line_out(line_out), .exposure_start(exp_p), .readout_start(ro_p),
    .frame_begin(fb_p), .frame_active(f_act));
  ltio_far_side i_far (.sys_clk(sys_clk), .line_in(line_in),
    .first_timer_done(tmr), .first_counter_done(cnt));
  // Model tally of events and output edge times
  always @(posedge sys_clk) begin
    n_exp += int'(exp_p === 1'b1);
    n_ro += int'(ro_p === 1'b1);
    n_fb += int'(fb_p === 1'b1);
    for (int b = 0; b < 2; b++) begin
      if (line_out[b] === 1'b1 && prv[b] !== 1'b1) begin
        n_rise[b]++;
        t_rise[b] = $realtime;
      end
      if (line_out[b] !== 1'b1 && prv[b] === 1'b1) t_fall[b] = $realtime;
    end
    prv <= line_out;
  end
  // ==========================================
  // Bus and compare tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    t_take = $realtime;
  endtask : wr
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", s, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic rng(input string s, input int lo, hi, g);
    chk(s, 32'(lo), (g < lo || g > hi) ? 32'(g) : 32'(lo));
  endtask : rng
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask : rd
  task automatic clr();
    n_exp = 0;
    n_ro = 0;
    n_fb = 0;
  endtask : clr
  task automatic rst();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    clr();
  endtask : rst
  task automatic close_out();
    $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Watchdog, well past the expected run
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h91C6));
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h0C, 32'h64);
    rd(8'h10, 32'h0);
    rd(8'h3C, 32'h0);
    clr();
    wr(8'h00, 32'h210);
    i_far.ticks(2, 3, 1'b0);
    chk("idle_exp", 0, n_exp);
    chk("idle_fb", 0, n_fb);
    // Single frames from timer, counter and host trigger
    for (int s = 1; s < 4; s++) begin
      h = 1 + $urandom % 4;
      clr();
      wr(8'h0C, 32'(h));
      // Frame begin is honoured only once acquisition is already on
      wr(8'h00, 32'h003 | 32'(s << 4));
      wr(8'h00, 32'h203 | 32'(s << 4));
      for (int k = 0; k <= h; k++) begin
        if (s == 3) wr(8'h00, 32'h133);
        else i_far.ticks(1, 4, s == 2);
      end
      repeat (4) @(posedge sys_clk);
      chk("exp", 32'(h), n_exp);
      chk("ro", 32'(h), n_ro);
      chk("fb", 1, n_fb);
      chk("idle", 0, f_act);
    end
    // Filtered line trigger, rising then any edge
    clr();
    wr(8'h10, 32'h2);
    wr(8'h0C, 32'h2);
    wr(8'h00, 32'h203);
    i_far.level(0, 1'b1, 100);
    i_far.level(0, 1'b0, 800);
    i_far.level(0, 1'b1, 800);
    i_far.level(0, 1'b0, 800);
    chk("line_exp", 1, n_exp);
    wr(8'h00, 32'h0B);
    i_far.level(0, 1'b1, 800);
    i_far.level(0, 1'b0, 800);
    chk("any_ro", 2, n_ro);
    // Strobed pulses; line 4 refires while busy
    wr(8'h14, 32'hA);
    wr(8'h18, 32'h0);
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h2);
    n_rise = '{0, 0};
    wr(8'h2C, 32'h3);
    t0 = t_take;
    repeat (300) @(posedge sys_clk);
    wr(8'h2C, 32'h2);
    repeat (700) @(posedge sys_clk);
    rng("lag3", 2, 3, int'((t_rise[0] - t0) / 5));
    rng("wid3", 1, 202, int'((t_fall[0] - t_rise[0]) / 5));
    rng("lag4", 200, 403, int'((t_rise[1] - t0) / 5));
    rng("wid4", 200, 403, int'((t_fall[1] - t_rise[1]) / 5));
    chk("rise4", 1, n_rise[1]);
    // Host levels, immediate then held for strobe
    wr(8'h14, 32'h0);
    wr(8'h28, 32'h1);
    repeat (3) @(posedge sys_clk);
    #1 chk("lvl", 1, {30'h0, line_out});
    wr(8'h28, 32'hA);
    repeat (3) @(posedge sys_clk);
    #1 chk("held", 0, {30'h0, line_out});
    wr(8'h2C, 32'h2);
    repeat (3) @(posedge sys_clk);
    #1 chk("fired", 2, {30'h0, line_out});
    // Continuous frames share the read-out trigger
    rst();
    wr(8'h0C, 32'h2);
    wr(8'h00, 32'h17);
    i_far.ticks(5, 4, 1'b0);
    repeat (4) @(posedge sys_clk);
    chk("c_exp", 5, n_exp);
    chk("c_ro", 4, n_ro);
    chk("c_fb", 3, n_fb);
    // Free run from internal timers
    rst();
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h14);
    wr(8'h0C, 32'h2);
    wr(8'h00, 32'h2);
    repeat (6000) @(posedge sys_clk);
    chk("free_fb", 1, n_fb > 0);
    chk("free_exp", 1, n_exp > 0);
    close_out();
  end
endmodule : testbench
